// [bench/csms_card_model.sv]
// Card in the socket: detect pins and interrogation results
`timescale 1ns/1ps
module csms_card_model (
	input  wire logic             clock_i,
	input  wire logic             insert_i,
	input  wire logic             reprobe_i,
	output logic                  cd1_o,
	output logic                  cd2_o,
	output logic                  probing_o,
	output csms_pkg::csms_probe_t probe_o
);
	logic [3:0] cnt   = 4'h0;
	logic [1:0] phase = 2'h0;

	always_ff @(posedge clock_i) begin
		phase <= phase + 2'h1;
		if (reprobe_i) begin
			cnt <= 4'h6;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end

	assign probing_o = (cnt > 4'h1);
	// Detect pin bounces in two-cycle runs during interrogation, slow enough
	// to pass the agreement filter, so a leak shows up
	assign cd1_o     = probing_o ? phase[1] : ~insert_i;
	assign cd2_o     = ~insert_i;
	// Results stand ready early; only the done pulse may load them
	assign probe_o   = '{done: (cnt == 4'h1), cardbus: insert_i, bit16: ~insert_i, volts: 4'h5};
endmodule

// [bench/csms_monitor.sv]
// Port checker for the socket mask and present-state registers
`timescale 1ns/1ps
module csms_monitor (
	input wire logic                    clock_i,
	input wire logic                    rst_i,
	input wire csms_pkg::csms_reg_req_t reg_req_i,
	input wire logic                    dev_ctl_5v_off_i,
	input wire logic [31:0]             reg_rdata_o,
	input wire logic                    reg_rvalid_o,
	input wire logic                    status_change_interrupt_o,
	input wire logic                    card_reprobe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	logic rd_mask;
	logic rd_state;
	logic wr_mask;
	logic wr_clear;
	logic force_probe;

	assign rd_mask     = reg_req_i.rd && reg_req_i.addr == csms_pkg::OFS_MASK;
	assign rd_state    = reg_req_i.rd && reg_req_i.addr == csms_pkg::OFS_STATE;
	assign wr_mask     = reg_req_i.wr && reg_req_i.addr == csms_pkg::OFS_MASK;
	assign wr_clear    = reg_req_i.wr && reg_req_i.addr == csms_pkg::OFS_EVENT
		&& reg_req_i.wdata[3:0] == 4'hF;
	assign force_probe = reg_req_i.wr && reg_req_i.addr == csms_pkg::OFS_FORCE
		&& reg_req_i.wdata[csms_pkg::POS_RETEST];

	a_read_answered: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read not answered");
	a_mask_upper_zero: assert property (rd_mask |=> reg_rdata_o[31:4] == '0)
		else $error("mask upper bits not zero");
	a_state_gap_zero: assert property (rd_state |=> reg_rdata_o[26:14] == '0)
		else $error("present state gap bits not zero");
	a_five_volt_cfg: assert property (rd_state |=> reg_rdata_o[28] == !$past(dev_ctl_5v_off_i, 2))
		else $error("5 V socket bit does not follow override");
	a_mask_off_quiet: assert property (wr_mask && reg_req_i.wdata[3:0] == 4'h0 ##1 !wr_mask
		|=> !status_change_interrupt_o) else $error("interrupt with all masks off");
	a_reserved_cd_quiet: assert property (wr_mask && reg_req_i.wdata[3:0] inside {4'h2, 4'h4}
		##1 !wr_mask |=> !status_change_interrupt_o) else $error("reserved detect mask enabled");
	a_clear_all_quiet: assert property (wr_clear ##1 !reg_req_i.wr
		|=> !status_change_interrupt_o) else $error("interrupt stays after clearing flags");
	a_reprobe_follows: assert property (force_probe |=> card_reprobe_o)
		else $error("no reprobe after force write");
	a_reprobe_caused: assert property (card_reprobe_o |-> $past(force_probe))
		else $error("reprobe without force write");
endmodule

bind csms_top csms_monitor i_csms_monitor (
	.clock_i                   (clock_i),
	.rst_i                     (rst_i),
	.reg_req_i                 (reg_req_i),
	.dev_ctl_5v_off_i          (dev_ctl_5v_off_i),
	.reg_rdata_o               (reg_rdata_o),
	.reg_rvalid_o              (reg_rvalid_o),
	.status_change_interrupt_o (status_change_interrupt_o),
	.card_reprobe_o            (card_reprobe_o)
);

// [bench/tb_csms_top.sv]
// Self-checking bench for the socket mask and present-state registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_csms_top;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic                    clk = 1'b0;
	logic                    rst;
	csms_pkg::csms_reg_req_t req;
	csms_pkg::csms_pins_t    pins;
	csms_pkg::csms_probe_t   probe;
	logic                    ins, csts, bus_rst, glb_rst, powered, wake, cfg5;
	logic                    cd1, cd2, probing, reprobe, irq, rvalid;
	logic [31:0]             rdata;
	logic [31:0]             en [4] = '{32'h0000_0001, 32'h0000_0006, 32'h0000_0006, 32'h0000_0008};
	int                      n_fail = 0;
	int                      total_checks = 0;

	always #4 clk = ~clk;
	assign pins = '{ready: ins, csts: csts, cd2: cd2, cd1: cd1, bus_rst: bus_rst, glb_rst: glb_rst};

	csms_top i_csms_top (
		.clock_i                   (clk),
		.rst_i                     (rst),
		.reg_req_i                 (req),
		.pins_i                    (pins),
		.probe_i                   (probe),
		.card_probing_i            (probing),
		.socket_powered_i          (powered),
		.power_mgmt_wake_event_i   (wake),
		.dev_ctl_5v_off_i          (cfg5),
		.reg_rdata_o               (rdata),
		.reg_rvalid_o              (rvalid),
		.status_change_interrupt_o (irq),
		.card_reprobe_o            (reprobe)
	);

	csms_card_model i_csms_card_model (
		.clock_i   (clk),
		.insert_i  (ins),
		.reprobe_i (reprobe),
		.cd1_o     (cd1),
		.cd2_o     (cd2),
		.probing_o (probing),
		.probe_o   (probe)
	);

	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// An idle cycle after each access keeps strobes from being re-driven in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		cyc(1);
		req.wr = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
		input string nm);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		cyc(1);
		req.rd = 1'b0;
		`CHK(nm, 1'b1, rvalid)
		`CHK(nm, ex & m, rdata & m)
		cyc(1);
	endtask

	task automatic wait_irq(input logic ex);
		for (int k = 0; k < 8 && irq !== ex; k++) cyc(1);
		`CHK("interrupt", ex, irq)
		if (irq !== ex) end_of_test();
	endtask

	task automatic pulse(input logic g);
		glb_rst = g;
		bus_rst = ~g;
		cyc(8);
		glb_rst = 1'b0;
		bus_rst = 1'b0;
		cyc(8);
	endtask

	initial begin
		rst = 1'b1;
		req = '0;
		{ins, csts, bus_rst, glb_rst, powered, wake, cfg5} = '0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		cyc(6);
		rd(csms_pkg::OFS_MASK, ALL, 32'h0000_0000, "mask reset");
		rd(csms_pkg::OFS_STATE, ALL, 32'h3000_0006, "state reset");
		wr(csms_pkg::OFS_MASK, ALL);
		rd(csms_pkg::OFS_MASK, ALL, 32'h0000_000F, "mask bits");
		for (int i = 0; i < 4; i++) begin
			wr(csms_pkg::OFS_MASK, 32'h0000_0000);
			wr(csms_pkg::OFS_EVENT, 32'h0000_000F);
			wr(csms_pkg::OFS_FORCE, 32'h0000_0001 << i);
			cyc(3);
			`CHK("masked interrupt", 1'b0, irq)
			rd(csms_pkg::OFS_EVENT, ALL, 32'h0000_0001 << i, "masked event");
			for (int j = 0; j < 2; j++) begin
				wr(csms_pkg::OFS_MASK, 32'h0000_0002 << j);
				cyc(3);
				`CHK("reserved mask", 1'b0, irq)
			end
			// Flag already pending when the mask opens must still interrupt
			wr(csms_pkg::OFS_MASK, en[i]);
			wait_irq(1'b1);
			wr(csms_pkg::OFS_EVENT, 32'h0000_000F);
			wait_irq(1'b0);
		end
		wr(csms_pkg::OFS_MASK, 32'h0000_0000);
		{ins, powered, csts} = 3'b111;
		cyc(12);
		rd(csms_pkg::OFS_EVENT, ALL, 32'h0000_000F, "pin events");
		rd(csms_pkg::OFS_STATE, 32'h0000_3C7F, 32'h0000_0049, "inserted");
		wr(csms_pkg::OFS_EVENT, 32'h0000_000F);
		wr(csms_pkg::OFS_FORCE, 32'h0000_4000);
		rd(csms_pkg::OFS_STATE, 32'h0000_0006, 32'h0000_0000, "detect frozen");
		cyc(12);
		rd(csms_pkg::OFS_EVENT, 32'h0000_0006, 32'h0000_0000, "probe events");
		rd(csms_pkg::OFS_STATE, 32'h0000_3C30, 32'h0000_1420, "probed");
		// A CardBus card flags only the rising edge of its status pin
		csts = 1'b0;
		cyc(12);
		rd(csms_pkg::OFS_EVENT, 32'h0000_0001, 32'h0000_0000, "cardbus fall");
		csts = 1'b1;
		cyc(12);
		rd(csms_pkg::OFS_EVENT, 32'h0000_0001, 32'h0000_0001, "cardbus rise");
		wr(csms_pkg::OFS_FORCE, 32'hC800_2000);
		rd(csms_pkg::OFS_STATE, 32'hF800_3C00, 32'hD800_3400, "forced");
		cfg5 = 1'b1;
		cyc(3);
		rd(csms_pkg::OFS_STATE, 32'h1000_0000, 32'h0000_0000, "5 V off");
		cfg5 = 1'b0;
		cyc(3);
		rd(csms_pkg::OFS_STATE, 32'h1000_0000, 32'h1000_0000, "5 V on");
		wr(csms_pkg::OFS_MASK, ALL);
		wake = 1'b1;
		pulse(1'b0);
		rd(csms_pkg::OFS_MASK, ALL, 32'h0000_000F, "mask kept");
		wake = 1'b0;
		pulse(1'b0);
		rd(csms_pkg::OFS_MASK, ALL, 32'h0000_0000, "mask bus reset");
		wr(csms_pkg::OFS_MASK, ALL);
		wake = 1'b1;
		pulse(1'b1);
		rd(csms_pkg::OFS_MASK, ALL, 32'h0000_0000, "mask global reset");
		end_of_test();
	end
endmodule

// [hdl/csms_event.sv]
// Sticky socket event flags with write-one-to-clear and context clear
`timescale 1ns/1ps
module csms_event (
	input  wire logic                           clock_i,
	input  wire logic                           ctx_clr_i,
	input  wire logic [csms_pkg::EVENT_W-1:0]   set_i,
	input  wire logic [csms_pkg::EVENT_W-1:0]   clr_i,
	output logic      [csms_pkg::EVENT_W-1:0]   flag_o
);

	genvar gi;
	generate
		for (gi = 0; gi < csms_pkg::EVENT_W; gi++) begin : g_flag
			// A set in the same cycle as a software clear is kept
			always_ff @(posedge clock_i) begin
				if (ctx_clr_i) begin
					flag_o[gi] <= csms_pkg::EVENT_RST[gi];
				end else if (set_i[gi]) begin
					flag_o[gi] <= 1'b1;
				end else if (clr_i[gi]) begin
					flag_o[gi] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

// [hdl/csms_sync.sv]
// Three-stage synchroniser with agreement filter for the socket pins
`timescale 1ns/1ps
module csms_sync (
	input  wire logic                         clock_i,
	input  wire logic [csms_pkg::PIN_W-1:0]   async_i,
	output logic      [csms_pkg::PIN_W-1:0]   level_o
);

	logic [csms_pkg::PIN_W-1:0] stage1;
	logic [csms_pkg::PIN_W-1:0] stage2;
	logic [csms_pkg::PIN_W-1:0] stage3;

	genvar gi;
	generate
		for (gi = 0; gi < csms_pkg::PIN_W; gi++) begin : g_bit
			always_ff @(posedge clock_i) begin
				stage1[gi] <= async_i[gi];
				stage2[gi] <= stage1[gi];
				stage3[gi] <= stage2[gi];
			end

			// Only take a level once the last two stages agree
			always_ff @(posedge clock_i) begin
				if (stage2[gi] == stage3[gi]) begin
					level_o[gi] <= stage3[gi];
				end
			end
		end
	endgenerate

endmodule

// [hdl/csms_top.sv]
// Socket mask and present-state registers with event flags and status interrupt
//
// Overview of operation
// RULE_01 - Mask register selects events raising status interrupt
// RULE_02 - Event flags set regardless of mask bits
// RULE_03 - Unused mask and state bits read zero
// RULE_04 - Mask bit 3 gates power-cycle interrupt, reset 0
// RULE_05 - Detect mask 11 enables insertion interrupt, reset 00
// RULE_06 - Mask bit 0 gates card-status interrupt, reset 0
// RULE_07 - Power-event enabled: only global reset clears mask
// RULE_08 - Present state shows socket status and forced writes
// RULE_09 - Card voltage and type update only on insertion; code loads them at each interrogation end (probe_i.done)
// RULE_10 - Detect changes during identification are not shown
// RULE_11 - Y and X socket bits zero unless forced
// RULE_12 - 3.3 V socket bit one unless forced
// RULE_13 - 5 V socket bit one unless config override
// RULE_14 - Bit 27 reports zoomed video support
// RULE_15 - Card voltage bits; force write of one sets
// RULE_16 - Reset value 3000_00XX, live bits follow pins
// RULE_17 - Interrupt while any enabled flag is set
// RULE_18 - Detect bit 0 when pin low, 1 when high
// RULE_19 - Bit 3 zero when powered down, one powered
// RULE_20 - Reserved detect mask codes act as disabled
`timescale 1ns/1ps
module csms_top (
	input  wire logic                      clock_i,
	input  wire logic                      rst_i,
	input  wire csms_pkg::csms_reg_req_t   reg_req_i,
	input  wire csms_pkg::csms_pins_t      pins_i,
	input  wire csms_pkg::csms_probe_t     probe_i,
	input  wire logic                      card_probing_i,
	input  wire logic                      socket_powered_i,
	input  wire logic                      power_mgmt_wake_event_i,
	input  wire logic                      dev_ctl_5v_off_i,
	output logic [31:0]                    reg_rdata_o,
	output logic                           reg_rvalid_o,
	output logic                           status_change_interrupt_o,
	output logic                           card_reprobe_o
);

	// Synchronised pin levels
	csms_pkg::csms_pins_t pins_s;

	// Reset qualifiers
	logic global_reset_in;
	logic host_bus_reset_in;
	logic ctx_clr;
	logic plain_clr;

	// Decoded register writes
	logic wr_event;
	logic wr_mask;
	logic wr_force;
	logic [31:0] wdata;

	// Mask register fields
	logic power_cycle_irq_mask;
	logic [1:0] card_detect_irq_mask;
	logic card_status_irq_mask;
	logic [csms_pkg::EVENT_W-1:0] mask_eff;

	// Present-state fields
	logic socket_supports_y_volt;
	logic socket_supports_x_volt;
	logic socket_supports_3v3;
	logic socket_supports_5v;
	logic zoomed_video_capable;
	logic [csms_pkg::VOLT_W-1:0] card_volts;
	logic card_is_cardbus;
	logic card_is_16bit;
	logic socket_powered_flag;
	logic detect_status_one;
	logic detect_status_two;
	logic card_status_level;
	logic ready_level;

	// Previous values for change detection
	logic prev_powered;
	logic prev_detect_one;
	logic prev_detect_two;
	logic prev_status;

	// Detect freeze stretched past the end of interrogation
	logic [csms_pkg::DETECT_HOLD-1:0] probe_hold;
	logic                             detect_freeze;

	// Event flag plumbing
	logic [csms_pkg::EVENT_W-1:0] event_set;
	logic [csms_pkg::EVENT_W-1:0] event_clr;
	logic [csms_pkg::EVENT_W-1:0] event_flag;
	logic [31:0] mask_word;
	logic [31:0] state_word;
	logic [31:0] event_word;
	logic [31:0] next_rdata;

	csms_sync u_sync (
		.clock_i (clock_i),
		.async_i (pins_i),
		.level_o (pins_s)
	);

	assign global_reset_in   = rst_i | pins_s.glb_rst;
	assign host_bus_reset_in = pins_s.bus_rst;

	// Context bits survive a bus reset while wake events are armed
	assign ctx_clr   = global_reset_in
		| (host_bus_reset_in & ~power_mgmt_wake_event_i);  // [RULE_07]
	assign plain_clr = global_reset_in | host_bus_reset_in;

	assign wdata    = reg_req_i.wdata;
	assign wr_event = reg_req_i.wr && (reg_req_i.addr == csms_pkg::OFS_EVENT);
	assign wr_mask  = reg_req_i.wr && (reg_req_i.addr == csms_pkg::OFS_MASK);
	assign wr_force = reg_req_i.wr && (reg_req_i.addr == csms_pkg::OFS_FORCE);

	// Mask register
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			power_cycle_irq_mask <= csms_pkg::MASK_RST[csms_pkg::POS_POWER];  // [RULE_04]
			card_detect_irq_mask <= csms_pkg::MASK_RST[csms_pkg::POS_CD2:csms_pkg::POS_CD1];  // [RULE_05]
			card_status_irq_mask <= csms_pkg::MASK_RST[csms_pkg::POS_CSTS];  // [RULE_06]
		end else if (wr_mask) begin
			power_cycle_irq_mask <= wdata[csms_pkg::POS_POWER];
			card_detect_irq_mask <= wdata[csms_pkg::POS_CD2:csms_pkg::POS_CD1];
			card_status_irq_mask <= wdata[csms_pkg::POS_CSTS];
		end
	end

	// Effective per-event enables; reserved detect codes enable nothing
	always_comb begin
		mask_eff = '0;
		mask_eff[csms_pkg::POS_POWER] = power_cycle_irq_mask;  // [RULE_04]
		mask_eff[csms_pkg::POS_CD2] =
			(card_detect_irq_mask == csms_pkg::CD_MASK_ON);  // [RULE_05] [RULE_20]
		mask_eff[csms_pkg::POS_CD1] =
			(card_detect_irq_mask == csms_pkg::CD_MASK_ON);  // [RULE_05] [RULE_20]
		mask_eff[csms_pkg::POS_CSTS] = card_status_irq_mask;  // [RULE_06]
	end

	// Socket supply capability, only a force write alters Y, X and 3.3 V
	always_ff @(posedge clock_i) begin
		if (plain_clr) begin
			socket_supports_y_volt <= csms_pkg::STATE_RST[csms_pkg::POS_YV];  // [RULE_11]
			socket_supports_x_volt <= csms_pkg::STATE_RST[csms_pkg::POS_XV];  // [RULE_11]
			socket_supports_3v3    <= csms_pkg::STATE_RST[csms_pkg::POS_3V3];  // [RULE_12]
		end else if (wr_force) begin
			socket_supports_y_volt <= wdata[csms_pkg::POS_YV];  // [RULE_11] [RULE_08]
			socket_supports_x_volt <= wdata[csms_pkg::POS_XV];  // [RULE_11] [RULE_08]
			socket_supports_3v3    <= wdata[csms_pkg::POS_3V3];  // [RULE_12] [RULE_08]
		end
	end

	// The 5 V capability is steered only by the device control bit
	always_ff @(posedge clock_i) begin
		if (plain_clr) begin
			socket_supports_5v <= csms_pkg::STATE_RST[csms_pkg::POS_5V];  // [RULE_16]
		end else begin
			socket_supports_5v <= ~dev_ctl_5v_off_i;  // [RULE_13]
		end
	end

	// Zoomed video support is set through the force register
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			zoomed_video_capable <= csms_pkg::STATE_RST[csms_pkg::POS_ZV];
		end else if (wr_force) begin
			zoomed_video_capable <= wdata[csms_pkg::POS_ZV];  // [RULE_14] [RULE_08]
		end
	end

	// Card voltage support: loaded by interrogation, forced ones add to it
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			card_volts <= csms_pkg::VOLT_RST;
		end else if (probe_i.done) begin
			card_volts <= probe_i.volts;  // [RULE_09] [RULE_15]
		end else if (wr_force) begin
			card_volts <= card_volts
				| wdata[csms_pkg::POS_VOLT_HI:csms_pkg::POS_VOLT_LO];  // [RULE_15] [RULE_08]
		end
	end

	// Card type is only refreshed at the end of an interrogation
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			card_is_cardbus <= 1'b0;
			card_is_16bit   <= 1'b0;
		end else if (probe_i.done) begin
			card_is_cardbus <= probe_i.cardbus;  // [RULE_09]
			card_is_16bit   <= probe_i.bit16;  // [RULE_09]
		end
	end

	// Power state of the socket
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			socket_powered_flag <= 1'b0;  // [RULE_19]
		end else begin
			socket_powered_flag <= socket_powered_i;  // [RULE_19]
		end
	end

	// Pin levels sampled during identification are still in the synchroniser
	// when it ends, so the freeze is held on for that many more cycles
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			probe_hold <= '0;
		end else begin
			probe_hold <= {probe_hold[csms_pkg::DETECT_HOLD-2:0], card_probing_i};  // [RULE_10]
		end
	end

	assign detect_freeze = card_probing_i | (|probe_hold);  // [RULE_10]

	// Detect pins are frozen while the card is being identified
	always_ff @(posedge clock_i) begin
		if (plain_clr) begin
			detect_status_one <= pins_s.cd1;  // [RULE_16]
			detect_status_two <= pins_s.cd2;  // [RULE_16]
		end else if (!detect_freeze) begin
			detect_status_one <= pins_s.cd1;  // [RULE_18] [RULE_10]
			detect_status_two <= pins_s.cd2;  // [RULE_18] [RULE_10]
		end
	end

	// Live card status and ready levels
	always_ff @(posedge clock_i) begin
		card_status_level <= pins_s.csts;  // [RULE_16]
		ready_level       <= pins_s.ready;  // [RULE_16]
	end

	// Change detection history; reset copies current to avoid false events
	always_ff @(posedge clock_i) begin
		if (plain_clr) begin
			prev_powered    <= socket_powered_flag;
			prev_detect_one <= detect_status_one;
			prev_detect_two <= detect_status_two;
			prev_status     <= card_status_level;
		end else begin
			prev_powered    <= socket_powered_flag;
			prev_detect_one <= detect_status_one;
			prev_detect_two <= detect_status_two;
			prev_status     <= card_status_level;
		end
	end

	// Event sources: state changes and force writes, never gated by mask
	always_comb begin
		event_set = '0;
		event_set[csms_pkg::POS_POWER] = (socket_powered_flag != prev_powered);  // [RULE_02]
		event_set[csms_pkg::POS_CD2]   = (detect_status_two != prev_detect_two);  // [RULE_02]
		event_set[csms_pkg::POS_CD1]   = (detect_status_one != prev_detect_one);  // [RULE_02]
		// CardBus cards flag only the rising edge, 16-bit cards both edges
		if (card_is_cardbus) begin
			event_set[csms_pkg::POS_CSTS] = card_status_level & ~prev_status;
		end else begin
			event_set[csms_pkg::POS_CSTS] = card_status_level ^ prev_status;
		end
		if (wr_force) begin
			event_set = event_set | wdata[csms_pkg::EVENT_W-1:0];
		end
		if (plain_clr) begin
			event_set = '0;
		end
	end

	always_comb begin
		event_clr = '0;
		if (wr_event) begin
			event_clr = wdata[csms_pkg::EVENT_W-1:0];
		end
	end

	csms_event u_event (
		.clock_i   (clock_i),
		.ctx_clr_i (ctx_clr),
		.set_i     (event_set),
		.clr_i     (event_clr),
		.flag_o    (event_flag)
	);

	// Interrupt is a level of any flag whose enable is on, old flags included
	always_ff @(posedge clock_i) begin
		if (ctx_clr) begin
			status_change_interrupt_o <= 1'b0;
		end else begin
			status_change_interrupt_o <= |(event_flag & mask_eff);  // [RULE_01] [RULE_17]
		end
	end

	// Writing the retest bit starts a new interrogation
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			card_reprobe_o <= 1'b0;
		end else begin
			card_reprobe_o <= wr_force & wdata[csms_pkg::POS_RETEST];  // [RULE_08]
		end
	end

	// Read images; unlisted bits stay zero
	always_comb begin
		mask_word = '0;
		mask_word[csms_pkg::POS_POWER] = power_cycle_irq_mask;
		mask_word[csms_pkg::POS_CD2:csms_pkg::POS_CD1] = card_detect_irq_mask;
		mask_word[csms_pkg::POS_CSTS] = card_status_irq_mask;  // [RULE_03]
	end

	always_comb begin
		event_word = '0;
		event_word[csms_pkg::EVENT_W-1:0] = event_flag;
	end

	always_comb begin
		state_word = '0;  // [RULE_03]
		state_word[csms_pkg::POS_YV]  = socket_supports_y_volt;
		state_word[csms_pkg::POS_XV]  = socket_supports_x_volt;
		state_word[csms_pkg::POS_3V3] = socket_supports_3v3;
		state_word[csms_pkg::POS_5V]  = socket_supports_5v;
		state_word[csms_pkg::POS_ZV]  = zoomed_video_capable;
		state_word[csms_pkg::POS_VOLT_HI:csms_pkg::POS_VOLT_LO] = card_volts;
		state_word[csms_pkg::POS_READY]   = ready_level;
		state_word[csms_pkg::POS_CARDBUS] = card_is_cardbus;
		state_word[csms_pkg::POS_16BIT]   = card_is_16bit;
		state_word[csms_pkg::POS_POWER]   = socket_powered_flag;
		state_word[csms_pkg::POS_CD2]     = detect_status_two;
		state_word[csms_pkg::POS_CD1]     = detect_status_one;
		state_word[csms_pkg::POS_CSTS]    = card_status_level;
	end

	// Read decode; force register and unmapped offsets read zero
	always_comb begin
		next_rdata = '0;
		if (reg_req_i.addr == csms_pkg::OFS_EVENT) begin
			next_rdata = event_word;
		end else if (reg_req_i.addr == csms_pkg::OFS_MASK) begin
			next_rdata = mask_word;
		end else if (reg_req_i.addr == csms_pkg::OFS_STATE) begin
			next_rdata = state_word;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reg_rdata_o  <= '0;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

endmodule

// [pkg/csms_pkg.sv]
// Shared constants and carrier types for the socket mask and present-state registers
package csms_pkg;

	// Register byte offsets inside the socket window
	localparam logic [7:0] OFS_EVENT = 8'h00;
	localparam logic [7:0] OFS_MASK  = 8'h04;
	localparam logic [7:0] OFS_STATE = 8'h08;
	localparam logic [7:0] OFS_FORCE = 8'h0C;

	// Field widths
	localparam int EVENT_W = 4;
	localparam int VOLT_W  = 4;
	localparam int PIN_W   = 6;

	// Event and mask bit positions
	localparam int POS_CSTS     = 0;
	localparam int POS_CD1      = 1;
	localparam int POS_CD2      = 2;
	localparam int POS_POWER    = 3;

	// Present-state bit positions
	localparam int POS_16BIT    = 4;
	localparam int POS_CARDBUS  = 5;
	localparam int POS_READY    = 6;
	localparam int POS_VOLT_LO  = 10;
	localparam int POS_VOLT_HI  = 13;
	localparam int POS_ZV       = 27;
	localparam int POS_5V       = 28;
	localparam int POS_3V3      = 29;
	localparam int POS_XV       = 30;
	localparam int POS_YV       = 31;

	// Force-event bit that starts a new card interrogation
	localparam int POS_RETEST   = 14;

	// Cycles the detect freeze outlasts interrogation, covering the synchroniser lag
	localparam int DETECT_HOLD  = 4;

	// Reset values
	localparam logic [3:0]  MASK_RST   = 4'h0;
	localparam logic [31:0] STATE_RST  = 32'h3000_0000;
	localparam logic [3:0]  VOLT_RST   = 4'h0;
	localparam logic [3:0]  EVENT_RST  = 4'h0;

	// Card-detect mask encoding that enables the interrupt
	localparam logic [1:0]  CD_MASK_ON = 2'h3;

	// Register access request from the socket window
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} csms_reg_req_t;

	// Pin-level inputs that come from outside the clock domain
	typedef struct packed {
		logic ready;
		logic csts;
		logic cd2;
		logic cd1;
		logic bus_rst;
		logic glb_rst;
	} csms_pins_t;

	// Result of a card interrogation
	typedef struct packed {
		logic              done;
		logic              cardbus;
		logic              bit16;
		logic [VOLT_W-1:0] volts;
	} csms_probe_t;

endpackage
